// ---- bench/lvbc_regs_tb.sv ----
// self-checking bench for the regulator select and buck control bank
`timescale 1ns/1ps
`default_nettype none

module lvbc_regs_tb;
  logic       clock   = 1'b0;
  logic       sys_rst = 1'b1;
  logic       sleep_n = 1'b1;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic [2:0] seq_en  = 3'h0;
  logic [2:0] frc_on  = 3'h0;
  logic [7:0] rdata;
  logic [7:0] rdata_opt;
  logic [3:0] a_code;
  logic [3:0] b_code;
  logic [3:0] a_code_opt;
  logic [2:0] pwm;
  logic [2:0] pwm_opt;
  logic [2:0] run;
  logic [7:0] rv;
  int         miscompares = 0;
  int         n_tests = 0;

  always #20 clock = ~clock;

  lvbc_regs dut_u (
    .clock_i(clock), .sys_rst_i(sys_rst), .sleep_state_n_i(sleep_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .buck_seq_en_i(seq_en), .buck_force_on_i(frc_on), .reg_rdata_o(rdata),
    .reg_a_code_o(a_code), .reg_b_code_o(b_code), .buck_pwm_force_o(pwm),
    .buck_run_o(run)
  );

  // second factory option: low codes, buck three forced pwm
  lvbc_regs #(.LOW_VOLT_OPTION(1'b1), .BUCK3_PWM_OPTION(1'b1)) opt_u (
    .clock_i(clock), .sys_rst_i(sys_rst), .sleep_state_n_i(sleep_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .buck_seq_en_i(seq_en), .buck_force_on_i(frc_on), .reg_rdata_o(rdata_opt),
    .reg_a_code_o(a_code_opt), .reg_b_code_o(), .buck_pwm_force_o(pwm_opt),
    .buck_run_o()
  );

  task automatic check(input string name, input lvbc_pkg::lvbc_byte_type seen,
                       input lvbc_pkg::lvbc_byte_type exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clock);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    addr = a;
    rd = 1'b1;
    @(negedge clock);
    rd = 1'b0;
    d = rdata;
  endtask

  task automatic test_reset;
    rd_reg(8'h9a, rv);
    check("reg a reset", rv, 8'haa);
    check("reg a reset opt", rdata_opt, 8'h00);
    rd_reg(8'h9b, rv);
    check("reg b reset", rv, 8'hbb);
    check("reg b reset opt", rdata_opt, 8'h00);
    rd_reg(8'h9c, rv);
    check("ctrl reset", rv, 8'h07);
    check("ctrl reset opt", rdata_opt, 8'h27);
    check("code a awake", {4'h0, a_code}, 8'h0a);
    check("code b awake", {4'h0, b_code}, 8'h0b);
    check("code a opt", {4'h0, a_code_opt}, 8'h00);
    check("mode reset", {5'h00, pwm}, 8'h00);
    check("mode reset opt", {5'h00, pwm_opt}, 8'h04);
    $display("test reset done");
  endtask

  task automatic test_codes;
    wr_reg(8'h9a, 8'h35);
    wr_reg(8'h9b, 8'h6c);
    idle(2);
    check("code a normal", {4'h0, a_code}, 8'h05);
    check("code b normal", {4'h0, b_code}, 8'h0c);
    rd_reg(8'h9a, rv);
    check("reg a back", rv, 8'h35);
    rd_reg(8'h9b, rv);
    check("reg b back", rv, 8'h6c);
    sleep_n = 1'b0;
    idle(6);
    check("code a sleep", {4'h0, a_code}, 8'h03);
    check("code b sleep", {4'h0, b_code}, 8'h06);
    sleep_n = 1'b1;
    idle(6);
    check("code a wake", {4'h0, a_code}, 8'h05);
    check("code b wake", {4'h0, b_code}, 8'h0c);
    $display("test codes done");
  endtask

  task automatic test_buck;
    seq_en = 3'h5;
    frc_on = 3'h2;
    idle(3);
    check("run all on", {5'h00, run}, 8'h07);
    wr_reg(8'h9c, 8'hea);
    idle(3);
    rd_reg(8'h9c, rv);
    check("ctrl back", rv, 8'h2a);
    check("mode bits", {5'h00, pwm}, 8'h05);
    check("run off bits", {5'h00, run}, 8'h02);
    frc_on = 3'h0;
    idle(3);
    check("run no force", {5'h00, run}, 8'h00);
    wr_reg(8'h9c, 8'h3f);
    idle(3);
    check("mode all pwm", {5'h00, pwm}, 8'h07);
    check("run seq only", {5'h00, run}, 8'h05);
    $display("test buck done");
  endtask

  task automatic test_unmapped;
    wr_reg(8'h9d, 8'h55);
    rd_reg(8'h9d, rv);
    check("unmapped read", rv, 8'h00);
    rd_reg(8'h9a, rv);
    check("reg a kept", rv, 8'h35);
    $display("test unmapped done");
  endtask

  // write then read in the next cycle, then write and read in one cycle
  task automatic test_back_to_back;
    @(negedge clock);
    addr = 8'h9a;
    wdata = 8'h77;
    wr = 1'b1;
    @(negedge clock);
    wr = 1'b0;
    rd = 1'b1;
    @(negedge clock);
    check("reg a next read", rdata, 8'h77);
    addr = 8'h9b;
    wdata = 8'h99;
    wr = 1'b1;
    @(negedge clock);
    check("reg b read old", rdata, 8'h6c);
    wr = 1'b0;
    @(negedge clock);
    check("reg b read new", rdata, 8'h99);
    rd = 1'b0;
    $display("test back to back done");
  endtask

  // equal sleep and normal codes keep the output steady across sleep
  task automatic test_no_sleep_change;
    idle(2);
    check("code a equal awake", {4'h0, a_code}, 8'h07);
    check("code b equal awake", {4'h0, b_code}, 8'h09);
    sleep_n = 1'b0;
    idle(6);
    check("code a equal sleep", {4'h0, a_code}, 8'h07);
    check("code b equal sleep", {4'h0, b_code}, 8'h09);
    sleep_n = 1'b1;
    idle(6);
    $display("test no sleep change done");
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    idle(3);
    sys_rst = 1'b0;
    test_reset();
    test_codes();
    test_buck();
    test_unmapped();
    test_back_to_back();
    test_no_sleep_change();
    end_sim();
  end

  // hang guard, far beyond the fewer than a hundred cycles the tests need
  initial
  begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule

`default_nettype wire

// ---- core/lvbc_params.svh ----
// offsets, field positions and reset values of the regulator select and buck control bank
`ifndef LVBC_PARAMS_SVH
`define LVBC_PARAMS_SVH

`define LVBC_ADDR_REG_A       8'h9a
`define LVBC_ADDR_REG_B       8'h9b
`define LVBC_ADDR_BUCK_CTRL   8'h9c

`define LVBC_SLEEP_HI         7
`define LVBC_SLEEP_LO         4
`define LVBC_NORMAL_HI        3
`define LVBC_NORMAL_LO        0

`define LVBC_RSVD_HI          7
`define LVBC_RSVD_LO          6
`define LVBC_MODE_HI          5
`define LVBC_MODE_LO          3
`define LVBC_OFF_HI           2
`define LVBC_OFF_LO           0

`define LVBC_RST_A_CODE       4'ha
`define LVBC_RST_B_CODE       4'hb
`define LVBC_RST_LOW_CODE     4'h0
`define LVBC_RST_OFF_N        3'h7
`define LVBC_RST_MODE         3'h0
`define LVBC_RST_MODE_B3      3'h4
`define LVBC_RSVD_VALUE       2'h0
`define LVBC_UNMAPPED_VALUE   8'h00
`define LVBC_RST_RUN          3'h0

`endif

// ---- core/lvbc_pin_sync.sv ----
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module lvbc_pin_sync #(
  parameter bit RESET_LEVEL = 1'b1
) (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  output var  logic level_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s1_r <= RESET_LEVEL;
      s2_r <= RESET_LEVEL;
      s3_r <= RESET_LEVEL;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      level_r <= RESET_LEVEL;
    else if (s2_r == s3_r)
      level_r <= s2_r;
  end

  assign level_o = level_r;

endmodule

`default_nettype wire

// ---- core/lvbc_pkg.sv ----
// types shared by the regulator select and buck control bank
package lvbc_pkg;

  typedef logic [3:0] lvbc_code_type;
  typedef logic [7:0] lvbc_byte_type;
  typedef logic [2:0] lvbc_trio_type;

endpackage

// ---- core/lvbc_regs.sv ----
// regulator voltage select and buck mode / disable register bank
`timescale 1ns/1ps
`default_nettype none
`include "lvbc_params.svh"

// Functional notes
// - Each regulator uses its sleep code while the sleep input is low and its normal code while high.
// - Register 9Ah holds regulator A sleep code in bits 7..4 and normal code in bits 3..0, both writable.
// - Register 9Bh holds regulator B sleep code in bits 7..4 and normal code in bits 3..0, both writable.
// - Regulator A codes reset to 1010, or to 0000 under the low-voltage factory option.
// - Regulator B codes reset to 1011, or to 0000 under the low-voltage factory option.
// - Register 9Ch holds three writable buck mode bits in 5..3, three off bits in 2..0, zeros in 7..6.
// - Buck control resets to off bits 1 and mode bits 0, except buck three mode 1 under one option.
// - A mode bit of 0 selects automatic mode and 1 forces pulse-width modulation for that buck.
// - An off bit of 0 turns its buck off regardless of enable pins or its enable override.
module lvbc_regs #(
  parameter bit LOW_VOLT_OPTION = 1'b0,
  parameter bit BUCK3_PWM_OPTION = 1'b0
) (
  input  wire logic                  clock_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  sleep_state_n_i,
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [2:0]            buck_seq_en_i,
  input  wire logic [2:0]            buck_force_on_i,
  output var  logic [7:0]            reg_rdata_o,
  output var  logic [3:0]            reg_a_code_o,
  output var  logic [3:0]            reg_b_code_o,
  output var  logic [2:0]            buck_pwm_force_o,
  output var  logic [2:0]            buck_run_o
);

  localparam lvbc_pkg::lvbc_code_type A_RST =
    LOW_VOLT_OPTION ? `LVBC_RST_LOW_CODE : `LVBC_RST_A_CODE;
  localparam lvbc_pkg::lvbc_code_type B_RST =
    LOW_VOLT_OPTION ? `LVBC_RST_LOW_CODE : `LVBC_RST_B_CODE;
  localparam lvbc_pkg::lvbc_trio_type MODE_RST =
    BUCK3_PWM_OPTION ? `LVBC_RST_MODE_B3 : `LVBC_RST_MODE;

  lvbc_pkg::lvbc_code_type a_sleep_r;
  lvbc_pkg::lvbc_code_type a_norm_r;
  lvbc_pkg::lvbc_code_type b_sleep_r;
  lvbc_pkg::lvbc_code_type b_norm_r;
  lvbc_pkg::lvbc_trio_type mode_r;
  lvbc_pkg::lvbc_trio_type off_n_r;
  lvbc_pkg::lvbc_byte_type rdata_r;
  lvbc_pkg::lvbc_code_type a_code_r;
  lvbc_pkg::lvbc_code_type b_code_r;
  lvbc_pkg::lvbc_trio_type run_r;
  logic                    sleep_n_q;
  logic                    wr_a;
  logic                    wr_b;
  logic                    wr_ctrl;

  function automatic lvbc_pkg::lvbc_byte_type pack_codes(
    input lvbc_pkg::lvbc_code_type sleep_code,
    input lvbc_pkg::lvbc_code_type normal_code
  );
    pack_codes = {sleep_code, normal_code};
  endfunction

  function automatic lvbc_pkg::lvbc_code_type pick_code(
    input logic                    awake,
    input lvbc_pkg::lvbc_code_type sleep_code,
    input lvbc_pkg::lvbc_code_type normal_code
  );
    pick_code = awake ? normal_code : sleep_code;
  endfunction

  lvbc_pin_sync #(
    .RESET_LEVEL (1'b1)
  ) u_sleep_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (sleep_state_n_i),
    .level_o   (sleep_n_q)
  );

  assign wr_a    = reg_wr_i && (reg_addr_i == `LVBC_ADDR_REG_A);
  assign wr_b    = reg_wr_i && (reg_addr_i == `LVBC_ADDR_REG_B);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `LVBC_ADDR_BUCK_CTRL);

  // regulator A codes
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      a_sleep_r <= A_RST;
      a_norm_r  <= A_RST;
    end
    else if (wr_a)
    begin
      a_sleep_r <= reg_wdata_i[`LVBC_SLEEP_HI:`LVBC_SLEEP_LO];
      a_norm_r  <= reg_wdata_i[`LVBC_NORMAL_HI:`LVBC_NORMAL_LO];
    end
  end

  // regulator B codes
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      b_sleep_r <= B_RST;
      b_norm_r  <= B_RST;
    end
    else if (wr_b)
    begin
      b_sleep_r <= reg_wdata_i[`LVBC_SLEEP_HI:`LVBC_SLEEP_LO];
      b_norm_r  <= reg_wdata_i[`LVBC_NORMAL_HI:`LVBC_NORMAL_LO];
    end
  end

  // buck control; reserved bits have no storage
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mode_r  <= MODE_RST;
      off_n_r <= `LVBC_RST_OFF_N;
    end
    else if (wr_ctrl)
    begin
      mode_r  <= reg_wdata_i[`LVBC_MODE_HI:`LVBC_MODE_LO];
      off_n_r <= reg_wdata_i[`LVBC_OFF_HI:`LVBC_OFF_LO];
    end
  end

  // read data held until the next read
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rdata_r <= `LVBC_UNMAPPED_VALUE;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `LVBC_ADDR_REG_A:     rdata_r <= pack_codes(a_sleep_r, a_norm_r);
        `LVBC_ADDR_REG_B:     rdata_r <= pack_codes(b_sleep_r, b_norm_r);
        `LVBC_ADDR_BUCK_CTRL: rdata_r <= {`LVBC_RSVD_VALUE, mode_r, off_n_r};
        default:              rdata_r <= `LVBC_UNMAPPED_VALUE;
      endcase
    end
  end

  // voltage code handed to each regulator
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      a_code_r <= A_RST;
      b_code_r <= B_RST;
    end
    else
    begin
      a_code_r <= pick_code(sleep_n_q, a_sleep_r, a_norm_r);
      b_code_r <= pick_code(sleep_n_q, b_sleep_r, b_norm_r);
    end
  end

  // off bit wins over sequencer and override enables
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      run_r <= `LVBC_RST_RUN;
    else
      run_r <= off_n_r & (buck_seq_en_i | buck_force_on_i);
  end

  assign reg_rdata_o      = rdata_r;
  assign reg_a_code_o     = a_code_r;
  assign reg_b_code_o     = b_code_r;
  assign buck_pwm_force_o = mode_r;
  assign buck_run_o       = run_r;

  chk_sleep_code_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    !sleep_n_q |=> reg_a_code_o == $past(a_sleep_r))
    else $error("regulator A not on sleep code while asleep");

  chk_normal_code_b: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    sleep_n_q |=> reg_b_code_o == $past(b_norm_r))
    else $error("regulator B not on normal code while awake");

  chk_reg_a_write: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    wr_a ##1 reg_rd_i && reg_addr_i == `LVBC_ADDR_REG_A
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("regulator A register does not read back written value");

  chk_reg_b_write: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    wr_b |=> pack_codes(b_sleep_r, b_norm_r) == $past(reg_wdata_i))
    else $error("regulator B register lost a write");

  chk_reset_a_codes: assert property (
    @(posedge clock_i)
    $fell(sys_rst_i) |-> a_sleep_r == A_RST && a_norm_r == A_RST && a_code_r == A_RST)
    else $error("regulator A reset code wrong");

  chk_reset_b_codes: assert property (
    @(posedge clock_i)
    $fell(sys_rst_i) |-> b_sleep_r == B_RST && b_norm_r == B_RST)
    else $error("regulator B reset code wrong");

  chk_ctrl_reset: assert property (
    @(posedge clock_i)
    $fell(sys_rst_i) |-> off_n_r == `LVBC_RST_OFF_N && mode_r == MODE_RST)
    else $error("buck control reset value wrong");

  chk_ctrl_write_mode: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    wr_ctrl |=> buck_pwm_force_o == $past(reg_wdata_i[`LVBC_MODE_HI:`LVBC_MODE_LO])
      && off_n_r == $past(reg_wdata_i[`LVBC_OFF_HI:`LVBC_OFF_LO]))
    else $error("buck control write not taken");

  chk_rsvd_read_zero: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == `LVBC_ADDR_BUCK_CTRL
      |=> reg_rdata_o[`LVBC_RSVD_HI:`LVBC_RSVD_LO] == `LVBC_RSVD_VALUE)
    else $error("reserved control bits read nonzero");

  chk_buck_forced_off: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    ##1 (buck_run_o & ~$past(off_n_r)) == 3'h0
      && buck_run_o == ($past(off_n_r) & ($past(buck_seq_en_i) | $past(buck_force_on_i))))
    else $error("buck running although its off bit is clear");

endmodule

`default_nettype wire
